//--- rotate_unit_consts.svh
// Constants for the prefixed rotate unit: register offsets, bytes, fields and lengths.
`ifndef ROTATE_UNIT_CONSTS_SVH
`define ROTATE_UNIT_CONSTS_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define OFF_CONTROL     8'h00
`define OFF_STATUS      8'h04
`define OFF_BCDE        8'h08
`define OFF_HLFA        8'h0c
`define OFF_INDEX       8'h10
`define OFF_PC          8'h14

// ------------------------------------------------------------
// Control bits and reset values
// ------------------------------------------------------------
`define CTRL_START      0
`define CTRL_CLR_DONE   1
`define CTRL_CLR_FAULT  2
`define RESET_BYTE      8'h00
`define RESET_WORD      16'h0000
`define RESET_DATA      32'h0000_0000

// ------------------------------------------------------------
// Instruction bytes and fields
// ------------------------------------------------------------
`define BYTE_BITOP      8'hcb
`define BYTE_FIRST_IDX  8'hdd
`define BYTE_SECOND_IDX 8'hfd
`define GROUP_HIGH      3'h0
`define FIELD_MEMORY    3'h6
`define SLOT_FLAGS      3'h6

// ------------------------------------------------------------
// Clock states per machine cycle
// ------------------------------------------------------------
`define LEN_FETCH       3'h4
`define LEN_DISP        3'h3
`define LEN_OP_INDEXED  3'h5
`define LEN_READ        3'h4
`define LEN_WRITE       3'h3

// ------------------------------------------------------------
// Flag bit positions
// ------------------------------------------------------------
`define FLAG_S          7
`define FLAG_Z          6
`define FLAG_H          4
`define FLAG_PV         2
`define FLAG_N          1
`define FLAG_C          0

`endif

//--- rotate_unit_pkg.sv
// Types shared by the prefixed rotate unit.
package rotate_unit_pkg;

    typedef enum logic [2:0] {
        ph_idle,
        ph_first,
        ph_prefix2,
        ph_disp,
        ph_opcode,
        ph_read,
        ph_write
    } phase_type;

    // Order follows bits 4:3 of the operation byte.
    typedef enum logic [1:0] {
        rotate_left_circular,
        rotate_right_circular,
        rotate_left_via_carry,
        rotate_right_via_carry
    } rot_type;

endpackage

//--- prefixed_rotate_unit.sv
// Prefixed byte-rotate execution unit with its APB register file and memory port.
//
// Contract
// - Second-index form adds signed displacement; left circular puts bit 7 in carry and bit 0.
// - Left via carry: bit 7 to carry, old carry to bit 0, rest shift up.
// - Left via carry decodes as prefix then 00010rrr; memory-pair form is 16h.
// - Right circular copies old bit 0 to carry and bit 7, rest shift down.
// - Right circular decodes as prefix then 00001rrr; memory-pair form is 0Eh.
// - Right via carry: bit 0 to carry, old carry to bit 7, rest shift down.
// - Right via carry uses operation byte 1Eh; indexed forms start with DD or FD.
// - Register field: 000 B, 001 C, 010 D, 011 E, 100 H, 101 L, 111 A.
// - Indexed stream is index prefix, bit prefix, displacement, operation byte, in order.
// - Register forms take 2 machine cycles, 8 states, as 4 and 4.
// - Memory-pair forms take 4 machine cycles, 15 states, as 4,4,4,3.
// - Indexed forms take 6 machine cycles, 23 states, as 4,4,3,5,4,3.
// - Sign from result bit 7, zero on zero result, half-carry and subtract cleared.
// - Parity/overflow set on even count of ones in the result.
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`include "rotate_unit_consts.svh"

module prefixed_rotate_unit
    import rotate_unit_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic [15:0]      mem_addr,
    output logic             mem_rd,
    output logic             mem_wr,
    output logic [7:0]       mem_wdata,
    input  wire logic [7:0]  mem_rdata
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Returns the new carry above the rotated byte.
    function automatic logic [8:0] rotate_byte(
        input rot_type    kind,
        input logic [7:0] v,
        input logic       cin
    );
        case (kind)
            rotate_left_circular:   rotate_byte = {v[7], v[6:0], v[7]};
            rotate_right_circular:  rotate_byte = {v[0], v[0], v[7:1]};
            rotate_left_via_carry:  rotate_byte = {v[7], v[6:0], cin};
            rotate_right_via_carry: rotate_byte = {v[0], cin, v[7:1]};
            default:                rotate_byte = {cin, v};
        endcase
    endfunction

    function automatic logic [7:0] flags_of(
        input logic [7:0] res,
        input logic       c
    );
        logic [7:0] f;
        f = `RESET_BYTE;
        f[`FLAG_S]  = res[7];
        f[`FLAG_Z]  = (res == `RESET_BYTE);
        f[`FLAG_H]  = 1'b0;
        f[`FLAG_N]  = 1'b0;
        f[`FLAG_PV] = ~^res;
        f[`FLAG_C]  = c;
        flags_of = f;
    endfunction

    function automatic logic [2:0] seg_len(
        input phase_type p,
        input logic      idx
    );
        case (p)
            ph_disp:   seg_len = `LEN_DISP;
            ph_opcode: seg_len = idx ? `LEN_OP_INDEXED : `LEN_FETCH;
            ph_read:   seg_len = `LEN_READ;
            ph_write:  seg_len = `LEN_WRITE;
            default:   seg_len = `LEN_FETCH;
        endcase
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == `OFF_CONTROL) || (a == `OFF_STATUS) ||
                    (a == `OFF_BCDE) || (a == `OFF_HLFA) ||
                    (a == `OFF_INDEX) || (a == `OFF_PC);
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    phase_type   phase_reg;
    phase_type   phase_next;
    logic [2:0]  tcnt_reg;
    logic        indexed_reg;
    logic        use_second_reg;
    logic [7:0]  disp_reg;
    logic [7:0]  op_reg;
    logic [15:0] pc_reg;
    logic [15:0] first_index_pointer_reg;
    logic [15:0] second_index_pointer_reg;
    logic [15:0] mem_addr_reg;
    logic [7:0]  mem_wdata_reg;
    logic [31:0] prdata_reg;
    logic        done_reg;
    logic        fault_reg;
    logic [7:0]  t_cnt_reg;
    logic [3:0]  m_cnt_reg;
    logic [7:0]  last_t_reg;
    logic [3:0]  last_m_reg;
    logic [7:0]  rf [0:7];

    logic        commit_reg;
    logic        commit_mem;
    logic        finish;
    logic        fault;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire logic        busy       = (phase_reg != ph_idle);
    wire logic        apb_setup  = psel & ~penable;
    wire logic        apb_access = psel & penable;
    wire logic        apb_wr     = apb_access & pwrite;
    wire logic        wr_ctrl    = apb_wr & (paddr == `OFF_CONTROL);
    // Data registers are locked while an instruction runs.
    wire logic        wr_bcde    = apb_wr & ~busy & (paddr == `OFF_BCDE);
    wire logic        wr_hlfa    = apb_wr & ~busy & (paddr == `OFF_HLFA);
    wire logic        wr_index   = apb_wr & ~busy & (paddr == `OFF_INDEX);
    wire logic        wr_pc      = apb_wr & ~busy & (paddr == `OFF_PC);
    wire logic        start_req  = wr_ctrl & pwdata[`CTRL_START] & ~busy;
    wire logic        clr_done   = wr_ctrl & pwdata[`CTRL_CLR_DONE];
    wire logic        clr_fault  = wr_ctrl & pwdata[`CTRL_CLR_FAULT];

    wire logic [31:0] status_word = {12'h000, last_m_reg, last_t_reg,
                                     5'h00, fault_reg, done_reg, busy};
    wire logic [31:0] read_word =
        (paddr == `OFF_STATUS) ? status_word :
        (paddr == `OFF_BCDE)   ? {rf[0], rf[1], rf[2], rf[3]} :
        (paddr == `OFF_HLFA)   ? {rf[4], rf[5], rf[6], rf[7]} :
        (paddr == `OFF_INDEX)  ? {second_index_pointer_reg, first_index_pointer_reg} :
        (paddr == `OFF_PC)     ? {16'h0000, pc_reg} :
                                 `RESET_DATA;

    assign pready    = 1'b1;
    assign pslverr   = apb_access & ~is_mapped(paddr);
    assign prdata    = prdata_reg;
    assign mem_addr  = mem_addr_reg;
    assign mem_wdata = mem_wdata_reg;
    assign mem_rd    = (phase_reg != ph_idle) & (phase_reg != ph_write);
    assign mem_wr    = (phase_reg == ph_write);

    // ------------------------------------------------------------
    // Datapath selection
    // ------------------------------------------------------------
    wire logic        last_state  = (tcnt_reg == seg_len(phase_reg, indexed_reg) - 3'h1);
    wire logic        is_fetch    = (phase_reg == ph_first) | (phase_reg == ph_prefix2) |
                                    (phase_reg == ph_disp) | (phase_reg == ph_opcode);
    wire logic [7:0]  op_src      = (phase_reg == ph_opcode) ? mem_rdata : op_reg;
    wire logic [2:0]  field       = op_src[2:0];
    wire logic        op_in_group = (mem_rdata[7:5] == `GROUP_HIGH);
    wire rot_type     kind        = rot_type'(op_src[4:3]);
    wire logic [7:0]  operand     = (phase_reg == ph_opcode) ? rf[field] : mem_rdata;
    wire logic [8:0]  rot_out     = rotate_byte(kind, operand, rf[`SLOT_FLAGS][`FLAG_C]);
    wire logic [7:0]  new_flags   = flags_of(rot_out[7:0], rot_out[8]);
    wire logic [15:0] memory_pointer_pair = {rf[4], rf[5]};
    wire logic [15:0] index_base  = use_second_reg ? second_index_pointer_reg
                                                   : first_index_pointer_reg;
    wire logic [15:0] index_addr  = index_base + {{8{disp_reg[7]}}, disp_reg};
    wire logic [15:0] operand_addr = indexed_reg ? index_addr : memory_pointer_pair;
    wire logic [15:0] pc_next     = pc_reg + {15'h0000, is_fetch & last_state};
    wire logic        mem_phase_next = (phase_next == ph_read) | (phase_next == ph_write);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        phase_next = phase_reg;
        commit_reg = 1'b0;
        commit_mem = 1'b0;
        finish     = 1'b0;
        fault      = 1'b0;
        case (phase_reg)
            ph_idle: begin
                if (start_req) begin
                    phase_next = ph_first;
                end
            end
            ph_first: begin
                if (last_state) begin
                    if (mem_rdata == `BYTE_BITOP) begin
                        phase_next = ph_opcode;
                    end else if (mem_rdata == `BYTE_FIRST_IDX ||
                                 mem_rdata == `BYTE_SECOND_IDX) begin
                        phase_next = ph_prefix2;
                    end else begin
                        fault      = 1'b1;
                        phase_next = ph_idle;
                    end
                end
            end
            ph_prefix2: begin
                if (last_state) begin
                    if (mem_rdata == `BYTE_BITOP) begin
                        phase_next = ph_disp;
                    end else begin
                        fault      = 1'b1;
                        phase_next = ph_idle;
                    end
                end
            end
            ph_disp: begin
                if (last_state) begin
                    phase_next = ph_opcode;
                end
            end
            ph_opcode: begin
                if (last_state) begin
                    if (!op_in_group) begin
                        fault      = 1'b1;
                        phase_next = ph_idle;
                    end else if (field == `FIELD_MEMORY) begin
                        phase_next = ph_read;
                    end else if (indexed_reg) begin
                        // Indexed register forms are outside this group.
                        fault      = 1'b1;
                        phase_next = ph_idle;
                    end else begin
                        commit_reg = 1'b1;
                        finish     = 1'b1;
                        phase_next = ph_idle;
                    end
                end
            end
            ph_read: begin
                if (last_state) begin
                    commit_mem = 1'b1;
                    phase_next = ph_write;
                end
            end
            ph_write: begin
                if (last_state) begin
                    finish     = 1'b1;
                    phase_next = ph_idle;
                end
            end
            default: begin
                phase_next = ph_idle;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg <= ph_idle;
            tcnt_reg  <= 3'h0;
        end else begin
            phase_reg <= phase_next;
            tcnt_reg  <= (busy && !last_state) ? tcnt_reg + 3'h1 : 3'h0;
        end
    end

    // ------------------------------------------------------------
    // Instruction capture
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            indexed_reg    <= 1'b0;
            use_second_reg <= 1'b0;
        end else if (phase_reg == ph_first && last_state) begin
            indexed_reg    <= (mem_rdata != `BYTE_BITOP);
            use_second_reg <= (mem_rdata == `BYTE_SECOND_IDX);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disp_reg <= `RESET_BYTE;
        end else if (phase_reg == ph_disp && last_state) begin
            disp_reg <= mem_rdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_reg <= `RESET_BYTE;
        end else if (phase_reg == ph_opcode && last_state) begin
            op_reg <= mem_rdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_wdata_reg <= `RESET_BYTE;
        end else if (commit_mem) begin
            mem_wdata_reg <= rot_out[7:0];
        end
    end

    // ------------------------------------------------------------
    // Addresses
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_reg <= `RESET_WORD;
        end else if (wr_pc) begin
            pc_reg <= pwdata[15:0];
        end else begin
            pc_reg <= pc_next;
        end
    end

    // Read and write of one operand share the address, so it is held across both.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_addr_reg <= `RESET_WORD;
        end else begin
            mem_addr_reg <= mem_phase_next ? operand_addr : pc_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_index_pointer_reg  <= `RESET_WORD;
            second_index_pointer_reg <= `RESET_WORD;
        end else if (wr_index) begin
            first_index_pointer_reg  <= pwdata[15:0];
            second_index_pointer_reg <= pwdata[31:16];
        end
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    // Slot 6 keeps the flags, since field code 110 names memory instead.
    for (genvar i = 0; i < 8; i++) begin : g_slot
        logic [7:0] slot_reg;
        wire logic  exec_we  = (commit_reg & (field == 3'(i))) |
                               ((commit_reg | commit_mem) & (3'(i) == `SLOT_FLAGS));
        wire logic  apb_we   = (i < 4) ? wr_bcde : wr_hlfa;
        wire logic [7:0] apb_byte = pwdata[8 * (3 - (i % 4)) +: 8];
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                slot_reg <= `RESET_BYTE;
            end else if (exec_we) begin
                slot_reg <= (3'(i) == `SLOT_FLAGS) ? new_flags : rot_out[7:0];
            end else if (apb_we) begin
                slot_reg <= apb_byte;
            end
        end
        assign rf[i] = slot_reg;
    end

    // ------------------------------------------------------------
    // Status and timing record
    // ------------------------------------------------------------
    // A completion in the same cycle as a clear leaves the bit set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_reg  <= 1'b0;
            fault_reg <= 1'b0;
        end else begin
            done_reg  <= finish | (done_reg & ~clr_done);
            fault_reg <= fault | (fault_reg & ~clr_fault);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t_cnt_reg <= `RESET_BYTE;
            m_cnt_reg <= 4'h0;
        end else if (start_req) begin
            t_cnt_reg <= `RESET_BYTE;
            m_cnt_reg <= 4'h0;
        end else if (busy) begin
            t_cnt_reg <= t_cnt_reg + 8'h01;
            m_cnt_reg <= m_cnt_reg + {3'h0, last_state};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_t_reg <= `RESET_BYTE;
            last_m_reg <= 4'h0;
        end else if (finish) begin
            last_t_reg <= t_cnt_reg + 8'h01;
            last_m_reg <= m_cnt_reg + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Captured in the setup phase so the access phase can finish at once.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= `RESET_DATA;
        end else if (apb_setup) begin
            prdata_reg <= read_word;
        end
    end

endmodule

//--- rotate_unit_checker.sv
// Port assertions for the prefixed rotate unit.
`timescale 1ns/1ns
module rotate_unit_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [15:0] mem_addr,
    input wire logic        mem_rd,
    input wire logic        mem_wr,
    input wire logic [7:0]  mem_wdata,
    input wire logic [7:0]  mem_rdata
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [4:0] run_reg;
    logic       rd_q_reg;
    wire        idle    = !mem_rd && !mem_wr;
    wire        start_w = psel && penable && pwrite && paddr == 8'h00 && pwdata[0];
    // Length of the last unbroken read run, which tells the form of the instruction.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_reg  <= 5'h00;
            rd_q_reg <= 1'b0;
        end else begin
            rd_q_reg <= mem_rd;
            if (mem_rd) begin
                run_reg <= rd_q_reg ? run_reg + 5'h01 : 5'h01;
            end
        end
    end
    sequence write_burst;
        mem_wr [*3] ##1 !mem_wr;
    endsequence
    sequence fetch_burst;
        mem_rd [*4];
    endsequence
    AST_SLVERR: assert property (psel && penable && paddr[1:0] == 2'h0
        |-> pslverr == (paddr > 8'h14)) else $error("slave error flag wrong");
    AST_START: assert property (start_w && idle |=> fetch_burst)
        else $error("first fetch not four states");
    AST_EXCL: assert property (!(mem_rd && mem_wr))
        else $error("read and write together");
    AST_WRITE_LEN: assert property ($rose(mem_wr) |-> write_burst)
        else $error("write cycle not three states");
    AST_RD_RUN: assert property ($rose(mem_wr) |-> run_reg == 5'h0c || run_reg == 5'h14)
        else $error("read run before write has wrong length");
    AST_SAME_ADDR: assert property ($rose(mem_wr) |-> $past(mem_rd) && $stable(mem_addr))
        else $error("write address differs from read address");
    AST_WR_HOLD: assert property (mem_wr && $past(mem_wr)
        |-> $stable(mem_addr) && $stable(mem_wdata)) else $error("write cycle not steady");
    AST_WR_ROT: assert property ($rose(mem_wr) |-> mem_wdata[6:0] == $past(mem_rdata[7:1])
        || mem_wdata[7:1] == $past(mem_rdata[6:0]))
        else $error("written byte is not a rotate of the read byte");
endmodule

bind prefixed_rotate_unit rotate_unit_checker rotate_unit_checker_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata));

//--- rotate_mem_model.sv
// Byte memory that feeds opcode and operand bytes to the rotate unit.
`timescale 1ns/1ns
module rotate_mem_model (
    input  wire logic        pclk,
    input  wire logic [15:0] mem_addr,
    input  wire logic        mem_rd,
    input  wire logic        mem_wr,
    input  wire logic [7:0]  mem_wdata,
    output logic [7:0]       mem_rdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_reg = 8'h00;
    // An idle bus shows the inverse of its last byte, so a stale sample cannot pass.
    assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_reg;
    always @(posedge pclk) begin
        if (mem_rd) last_reg <= mem[mem_addr];
        if (mem_wr) mem[mem_addr] <= mem_wdata;
    end
endmodule

//--- test_prefixed_rotate_unit.sv
// Self-checking testbench of the prefixed rotate unit.
`timescale 1ns/1ns
`include "rotate_unit_consts.svh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin num_errors++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module test_prefixed_rotate_unit;
    import rotate_unit_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_rd, mem_wr;
    logic [7:0]  paddr, mem_wdata, mem_rdata;
    logic [31:0] pwdata, prdata, rd_data;
    logic [15:0] mem_addr;
    logic        err_seen;
    int          num_errors = 0, cmp_count = 0, cycles = 0, seed = 31785, k, f, m;
    prefixed_rotate_unit prefixed_rotate_unit_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
    rotate_mem_model rotate_mem_model_inst (.pclk(pclk), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // The whole run needs about 1800 cycles; the ceiling leaves ample margin.
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            wrap_up();
        end
    end
    task wrap_up;
        $display("Comparisons %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd_data = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [8:0] rot(input logic [1:0] kd, input logic [7:0] v, input logic c);
        case (kd)
            2'h0: rot = {v[7], v[6:0], v[7]};
            2'h1: rot = {v[0], v[0], v[7:1]};
            2'h2: rot = {v[7], v[6:0], c};
            default: rot = {v[0], c, v[7:1]};
        endcase
    endfunction
    task automatic run_and_wait();
        int n;
        apb(1'b1, `OFF_CONTROL, 32'h0000_0001);
        n = 0;
        do begin
            apb(1'b0, `OFF_STATUS, 32'h0);
            n++;
        end while (rd_data[0] === 1'b1 && n < 50);
    endtask
    // Mode 0 is a register operand, 1 the pair pointer, 2 and 3 the two index pointers.
    task automatic exec(input logic [1:0] kd, input logic [2:0] fld, input logic [1:0] md);
        logic [7:0]  r [0:7];
        logic [15:0] pc, ix, iy, ea;
        logic [7:0]  d, op, v;
        logic [8:0]  res;
        int          n;
        for (n = 0; n < 8; n++) r[n] = 8'($random(seed));
        r[4][7] = 1'b1;
        pc = {4'h1, 12'($random(seed))};
        ix = {1'b1, 15'($random(seed))};
        iy = {1'b1, 15'($random(seed))};
        d = 8'($random(seed));
        op = {3'h0, kd, md == 2'h0 ? fld : 3'h6};
        ea = md == 2'h1 ? {r[4], r[5]} : (md == 2'h2 ? ix : iy) + {{8{d[7]}}, d};
        if (kd == 2'h1) r[0] = 8'h00;
        v = md == 2'h0 ? r[fld] : 8'($random(seed));
        if (kd == 2'h1 && md == 2'h3) v = 8'h00;
        res = rot(kd, v, r[6][0]);
        if (md >= 2'h2) begin
            rotate_mem_model_inst.mem[pc] = md == 2'h2 ? `BYTE_FIRST_IDX : `BYTE_SECOND_IDX;
            rotate_mem_model_inst.mem[pc + 16'h1] = `BYTE_BITOP;
            rotate_mem_model_inst.mem[pc + 16'h2] = d;
            rotate_mem_model_inst.mem[pc + 16'h3] = op;
        end else begin
            rotate_mem_model_inst.mem[pc] = `BYTE_BITOP;
            rotate_mem_model_inst.mem[pc + 16'h1] = op;
        end
        rotate_mem_model_inst.mem[ea] = v;
        apb(1'b1, `OFF_BCDE, {r[0], r[1], r[2], r[3]});
        apb(1'b1, `OFF_HLFA, {r[4], r[5], r[6], r[7]});
        apb(1'b1, `OFF_INDEX, {iy, ix});
        apb(1'b1, `OFF_PC, {16'h0, pc});
        run_and_wait();
        `CHK("done", 1'b1, rd_data[1])
        `CHK("states", md == 0 ? 8'h08 : md == 1 ? 8'h0f : 8'h17, rd_data[15:8])
        `CHK("mcycles", md == 0 ? 4'h2 : md == 1 ? 4'h4 : 4'h6, rd_data[19:16])
        if (md == 2'h0) r[fld] = res[7:0];
        r[6] = {res[7], res[7:0] == 8'h00, 3'h0, ~^res[7:0], 1'b0, res[8]};
        apb(1'b0, `OFF_BCDE, 32'h0);
        `CHK("bcde", {r[0], r[1], r[2], r[3]}, rd_data)
        apb(1'b0, `OFF_HLFA, 32'h0);
        `CHK("hlfa", {r[4], r[5], r[6], r[7]}, rd_data)
        apb(1'b0, `OFF_PC, 32'h0);
        `CHK("pc", pc + (md >= 2'h2 ? 16'h4 : 16'h2), rd_data[15:0])
        if (md != 2'h0) `CHK("memory", res[7:0], rotate_mem_model_inst.mem[ea])
        apb(1'b1, `OFF_CONTROL, 32'h0000_0002);
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `OFF_STATUS, 32'h0);
        `CHK("status after reset", 32'h0, rd_data)
        apb(1'b0, 8'h40, 32'h0);
        `CHK("unmapped error", 1'b1, err_seen)
        `CHK("unmapped data", 32'h0, rd_data)
        rotate_mem_model_inst.mem[16'h1000] = 8'hfb;
        apb(1'b1, `OFF_PC, 32'h0000_1000);
        run_and_wait();
        `CHK("fault", 1'b1, rd_data[2])
        apb(1'b1, `OFF_CONTROL, 32'h0000_0004);
        rotate_mem_model_inst.mem[16'h1100] = `BYTE_FIRST_IDX;
        rotate_mem_model_inst.mem[16'h1101] = 8'h16;
        apb(1'b1, `OFF_PC, 32'h0000_1100);
        run_and_wait();
        `CHK("fault second byte", 1'b1, rd_data[2])
        apb(1'b1, `OFF_CONTROL, 32'h0000_0004);
        for (k = 0; k < 4; k++) begin
            for (f = 0; f < 8; f++) if (f != 6) exec(2'(k), 3'(f), 2'h0);
            for (m = 1; m < 4; m++) exec(2'(k), 3'h6, 2'(m));
        end
        wrap_up();
    end
endmodule
